// >>> ssl_pkg.sv
// constants and checksum step shared by the stacked serial packet link
`default_nettype none
package ssl_pkg;
    localparam logic [5:0] SSL_BCAST_ADDR  = 6'h3f;
    localparam logic [5:0] SSL_MIN_ADDR    = 6'h01;
    localparam logic [5:0] SSL_MAX_ADDR    = 6'h3e;
    localparam logic [7:0] SSL_CRC_POLY    = 8'h07;
    localparam logic [7:0] SSL_CRC_INIT    = 8'h00;
    localparam logic [7:0] SSL_IDX_HDR     = 8'h00;
    localparam logic [7:0] SSL_IDX_REG     = 8'h01;
    localparam logic [7:0] SSL_IDX_LEN     = 8'h02;
    localparam logic [7:0] SSL_IDX_WDATA   = 8'h02;
    localparam logic [7:0] SSL_IDX_RDATA   = 8'h03;
    localparam logic [7:0] SSL_WR_BYTES    = 8'h03;
    localparam logic [7:0] SSL_WR_BYTES_CK = 8'h04;
    localparam logic [2:0] SSL_LAST_BIT    = 3'h7;
    localparam int         SSL_NSYNC       = 9;
    // positions in the synchroniser vector
    localparam int SSL_S_BASE   = 0;
    localparam int SSL_S_HCSN   = 1;
    localparam int SSL_S_HSCLK  = 2;
    localparam int SSL_S_HSDI   = 3;
    localparam int SSL_S_SCS    = 4;
    localparam int SSL_S_SSCLK  = 5;
    localparam int SSL_S_SSDI   = 6;
    localparam int SSL_S_NSDO   = 7;
    localparam int SSL_S_NALERT = 8;

    // one bit of the x^8+x^2+x+1 checksum, msb first
    function automatic logic [7:0] ssl_crc_step(input logic [7:0] crc, input logic b);
        ssl_crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? SSL_CRC_POLY : 8'h00);
    endfunction
endpackage
`default_nettype wire

// >>> ssl_link.sv
// packet receiver, relay and responder of the stacked serial packet link
`default_nettype none
module ssl_link
    import ssl_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       base_i,
    input  wire logic [5:0] dev_addr_i,
    input  wire logic       check_byte_disable_i,
    input  wire logic       fault_clear_i,
    input  wire logic       host_csn_i,
    input  wire logic       host_sclk_i,
    input  wire logic       host_serial_in_i,
    output logic            host_serial_out_o,
    output logic            host_serial_out_oe_o,
    input  wire logic       south_cs_i,
    input  wire logic       south_sclk_i,
    input  wire logic       south_serial_in_i,
    output logic            south_serial_out_o,
    output logic            south_alert_o,
    output logic            north_cs_o,
    output logic            north_sclk_o,
    output logic            north_serial_in_o,
    input  wire logic       north_serial_out_i,
    input  wire logic       north_alert_i,
    output logic [7:0]      rd_addr_o,
    input  wire logic [7:0] rd_data_i,
    output logic            wr_valid_o,
    input  wire logic       wr_ready_i,
    output logic [7:0]      wr_reg_o,
    output logic [7:0]      wr_data_o,
    output logic            crc_error_o,
    output logic            fault_o
);
    import ssl_pkg::*;

    localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("FIFO_DEPTH must be a power of two, at least 2");
        end
    endgenerate

    // first stage feeds only the second stage
    logic [SSL_NSYNC-1:0] sync1;
    logic [SSL_NSYNC-1:0] sync2;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {north_alert_i, north_serial_out_i, south_serial_in_i, south_sclk_i, south_cs_i,
                      host_serial_in_i, host_sclk_i, ~host_csn_i, base_i};
            sync2 <= sync1;
        end
    end

    logic base;
    logic cs_act;
    logic sclk;
    logic sdi;
    logic cs_prev;
    logic sclk_prev;
    assign base   = sync2[SSL_S_BASE];
    assign cs_act = base ? sync2[SSL_S_HCSN] : sync2[SSL_S_SCS];
    assign sclk   = base ? sync2[SSL_S_HSCLK] : sync2[SSL_S_SSCLK];
    assign sdi    = base ? sync2[SSL_S_HSDI] : sync2[SSL_S_SSDI];

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_prev   <= 1'b0;
            sclk_prev <= 1'b0;
        end else begin
            cs_prev   <= cs_act;
            sclk_prev <= sclk;
        end
    end

    logic cs_rise;
    logic cs_fall;
    logic sclk_fall;
    logic sclk_rise;
    assign cs_rise   = cs_act & ~cs_prev;
    assign cs_fall   = ~cs_act & cs_prev;
    assign sclk_fall = cs_act & ~cs_rise & sclk_prev & ~sclk;
    assign sclk_rise = cs_act & ~cs_rise & ~sclk_prev & sclk;

    logic       own_valid;
    logic [2:0] bitcnt;
    logic [7:0] bytecnt;
    logic [6:0] shreg;
    logic [7:0] hdr;
    logic [7:0] reg_off;
    logic [7:0] len;
    logic [7:0] crc;
    logic [7:0] tx_sh;
    logic [7:0] idx;
    logic [7:0] next_byte;
    logic       rd_mine;
    logic       wr_mine;
    logic       tx_on;
    logic       feed;

    assign own_valid = (dev_addr_i >= SSL_MIN_ADDR) && (dev_addr_i <= SSL_MAX_ADDR);
    assign rd_mine   = own_valid && !hdr[0] && (hdr[6:1] == dev_addr_i);
    assign wr_mine   = own_valid && hdr[0] &&
                       ((hdr[6:1] == dev_addr_i) || (hdr[6:1] == SSL_BCAST_ADDR));
    assign idx       = bytecnt - SSL_IDX_RDATA;
    assign tx_on     = rd_mine && (bytecnt >= SSL_IDX_RDATA);
    // filler bytes after the read data stay out of the checksum
    assign feed      = !(tx_on && (idx >= len));
    assign next_byte = {shreg, sdi};

    // receiver: restarts on every select assertion
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bitcnt  <= '0;
            bytecnt <= '0;
            shreg   <= '0;
            hdr     <= '0;
            reg_off <= '0;
            len     <= '0;
            crc     <= SSL_CRC_INIT;
        end else if (cs_rise) begin
            bitcnt  <= '0;
            bytecnt <= '0;
            shreg   <= '0;
            hdr     <= '0;
            reg_off <= '0;
            len     <= '0;
            crc     <= SSL_CRC_INIT;
        end else if (sclk_fall) begin
            shreg  <= next_byte[6:0];
            bitcnt <= bitcnt + 3'h1;
            if (feed) begin
                crc <= ssl_crc_step(crc, tx_on ? tx_sh[7] : sdi);
            end
            if (bitcnt == SSL_LAST_BIT) begin
                if (bytecnt != 8'hff) begin
                    bytecnt <= bytecnt + 8'h01;
                end
                case (bytecnt)
                    SSL_IDX_HDR: hdr     <= next_byte;
                    SSL_IDX_REG: reg_off <= next_byte;
                    SSL_IDX_LEN: len     <= next_byte;
                    default: ;
                endcase
            end
        end
    end

    // transmitter: loads at the rising edge that opens each outgoing byte
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_sh     <= '0;
            rd_addr_o <= '0;
        end else begin
            rd_addr_o <= reg_off + idx;
            if (cs_rise) begin
                tx_sh <= '0;
            end else if (sclk_rise) begin
                if (tx_on && bitcnt == 3'h0) begin
                    if (idx < len) begin
                        tx_sh <= rd_data_i;
                    end else if (idx == len && !check_byte_disable_i) begin
                        tx_sh <= crc;
                    end else begin
                        tx_sh <= '0;
                    end
                end else begin
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end

    // relays: everything rests low outside a selected packet
    logic out_bit;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            north_cs_o           <= 1'b0;
            north_sclk_o         <= 1'b0;
            north_serial_in_o    <= 1'b0;
            out_bit              <= 1'b0;
            host_serial_out_oe_o <= 1'b0;
        end else begin
            north_cs_o           <= cs_act && own_valid;
            north_sclk_o         <= cs_act && sclk;
            north_serial_in_o    <= cs_act && sdi;
            out_bit              <= cs_act && (tx_on ? tx_sh[7] : sync2[SSL_S_NSDO]);
            host_serial_out_oe_o <= cs_act && base;
        end
    end
    assign host_serial_out_o  = base & out_bit;
    assign south_serial_out_o = ~base & out_bit;

    // end of packet evaluation
    logic crc_fail;
    logic commit;
    logic byte_aligned;
    assign byte_aligned = (bitcnt == 3'h0);
    assign crc_fail = cs_fall && wr_mine && !check_byte_disable_i &&
                      !(byte_aligned && bytecnt == SSL_WR_BYTES_CK && crc == 8'h00);
    assign commit   = cs_fall && wr_mine && byte_aligned && !crc_fail &&
                      (bytecnt == (check_byte_disable_i ? SSL_WR_BYTES : SSL_WR_BYTES_CK));

    // flag is set only at packet end, so a read inside a packet sees the one before
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_error_o <= 1'b0;
        end else if (crc_fail) begin
            crc_error_o <= 1'b1;
        end else if (fault_clear_i) begin
            crc_error_o <= 1'b0;
        end
    end
    assign fault_o       = crc_error_o;
    assign south_alert_o = crc_error_o | sync2[SSL_S_NALERT];

    // accepted write waits here when the buffer is full
    logic       pend;
    logic [7:0] pend_reg;
    logic [7:0] pend_data;
    logic       push;
    logic       pop;
    logic       full;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [15:0] mem [FIFO_DEPTH];

    assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    assign push = pend && !full;
    assign wr_valid_o = (wptr != rptr);
    assign pop  = wr_valid_o && wr_ready_i;
    assign wr_reg_o  = mem[rptr[AW-1:0]][15:8];
    assign wr_data_o = mem[rptr[AW-1:0]][7:0];

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend      <= 1'b0;
            pend_reg  <= '0;
            pend_data <= '0;
        end else if (commit) begin
            pend      <= 1'b1;
            pend_reg  <= reg_off;
            pend_data <= len;
        end else if (push) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= {pend_reg, pend_data};
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_rx_restart: assert property (cs_rise |=> bitcnt == 3'h0 && bytecnt == 8'h00 && crc == 8'h00)
        else $error("receiver not restarted on select");
    a_north_blocked: assert property (dev_addr_i == 6'h00 |=> !north_cs_o)
        else $error("select passed north at address zero");
    a_link_rest: assert property (!cs_act |=> !north_sclk_o && !north_serial_in_o)
        else $error("vertical link not at rest");
    a_clock_relay: assert property (cs_act |=> north_sclk_o == $past(sclk))
        else $error("clock not relayed uninverted");
    a_out_quiet: assert property (!cs_act |=> !host_serial_out_o && !south_serial_out_o)
        else $error("serial output driven while idle");
    a_flag_sticky: assert property (crc_error_o && !fault_clear_i |=> crc_error_o)
        else $error("error flag dropped without clear");
    a_flag_still: assert property (cs_act && !fault_clear_i |=> crc_error_o == $past(crc_error_o))
        else $error("error flag moved inside a packet");
    a_alert_fail: assert property (crc_fail |=> south_alert_o && fault_o)
        else $error("check failure raised no alert");
    a_fail_discard: assert property (crc_fail |-> !commit ##1 !pend || $past(pend))
        else $error("failed packet committed");
    a_tx_owner: assert property (cs_act && !rd_mine && !sync2[SSL_S_NSDO] |=> !out_bit)
        else $error("foreign device transmitting");
    a_buf_full: assert property ((wptr - rptr) <= (AW+1)'(FIFO_DEPTH))
        else $error("buffer holds more than its depth");

    c_write_commit: cover property (commit ##[1:20] pop);
    c_read_crc: cover property (tx_on && idx == len && sclk_rise);
    c_check_fail: cover property (crc_fail);
    c_buf_stall: cover property (pend && full);
endmodule
`default_nettype wire

// >>> ssl_host_model.sv
// host-side serial master model that frames packets for the link
`default_nettype none
module ssl_host_model (
    input  wire logic clock_i,
    input  wire logic host_serial_out_i,
    output logic      host_csn_o,
    output logic      host_sclk_o,
    output logic      host_serial_in_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // four system cycles a half period gives the 800 ns link clock
    localparam int HALF = 4;
    initial begin
        host_csn_o = 1'b1;
        host_sclk_o = 1'b0;
        host_serial_in_o = 1'b0;
    end
    task automatic frame(input logic [7:0] tx [16], input int n, output logic [7:0] rx [16]);
        @(posedge clock_i);
        host_csn_o <= 1'b0;
        repeat (HALF) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                host_sclk_o <= 1'b1;
                host_serial_in_o <= tx[i][b];
                repeat (HALF) @(posedge clock_i);
                host_sclk_o <= 1'b0;
                // sample mid low phase: the answer trails the pin by the synchroniser delay
                repeat (2) @(posedge clock_i);
                rx[i][b] = host_serial_out_i;
                repeat (HALF - 2) @(posedge clock_i);
            end
        end
        host_serial_in_o <= 1'b0;
        repeat (HALF) @(posedge clock_i);
        host_csn_o <= 1'b1;
        repeat (3 * HALF) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// >>> ssl_link_bench.sv
// self-checking bench for the stacked serial packet link
`default_nettype none
module ssl_link_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ssl_pkg::*;
    logic        clock_i, resetn_i, base_i, check_byte_disable_i, fault_clear_i;
    logic        wr_ready_i, north_alert_i, host_csn_i, host_sclk_i, host_serial_in_i;
    logic [5:0]  dev_addr_i;
    logic [7:0]  rd_data_i, rd_addr_o, wr_reg_o, wr_data_o;
    logic        host_serial_out_o, host_serial_out_oe_o, south_serial_out_o, south_alert_o;
    logic        north_cs_o, north_sclk_o, north_serial_in_o, wr_valid_o, crc_error_o, fault_o;
    logic        south_cs_i, south_sclk_i, south_serial_in_i, link_sdo;
    logic [7:0]  tx [16];
    logic [7:0]  rx [16];
    logic [31:0] north_shift;
    logic [15:0] popped [$];
    int          error_cnt, samples_checked, cs_seen, oe_seen;

    ssl_link ssl_link_inst (
        .clock_i, .resetn_i, .base_i, .dev_addr_i, .check_byte_disable_i, .fault_clear_i,
        .host_csn_i, .host_sclk_i, .host_serial_in_i, .host_serial_out_o, .host_serial_out_oe_o,
        .south_cs_i, .south_sclk_i, .south_serial_in_i, .south_serial_out_o,
        .south_alert_o, .north_cs_o, .north_sclk_o, .north_serial_in_o,
        .north_serial_out_i(1'b0), .north_alert_i, .rd_addr_o, .rd_data_i, .wr_valid_o,
        .wr_ready_i, .wr_reg_o, .wr_data_o, .crc_error_o, .fault_o
    );
    ssl_host_model ssl_host_model_inst (
        .clock_i, .host_serial_out_i(link_sdo), .host_csn_o(host_csn_i),
        .host_sclk_o(host_sclk_i), .host_serial_in_o(host_serial_in_i)
    );

    // register file stand-in answers combinationally
    assign rd_data_i = rd_addr_o ^ 8'h5a;
    // a stacked device hears the same master through its south pins, select inverted
    assign south_cs_i        = ~host_csn_i;
    assign south_sclk_i      = host_sclk_i;
    assign south_serial_in_i = host_serial_in_i;
    assign link_sdo          = base_i ? host_serial_out_o : south_serial_out_o;
    always @(negedge north_sclk_o) north_shift <= {north_shift[30:0], north_serial_in_o};
    always @(posedge clock_i) begin
        if (north_cs_o === 1'b1) cs_seen <= cs_seen + 1;
        if (host_serial_out_oe_o === 1'b1) oe_seen <= oe_seen + 1;
        if (wr_valid_o === 1'b1 && wr_ready_i) popped.push_back({wr_reg_o, wr_data_o});
    end
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] b [16], input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++)
            for (int k = 7; k >= 0; k--)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // bad: 1 corrupts the check byte, 2 leaves it out
    task automatic send_write(input logic [5:0] a, input logic [7:0] r, input logic [7:0] d, input logic [1:0] bad);
        tx = '{default: 8'h00};
        tx[0] = {1'b0, a, 1'b1};
        tx[1] = r;
        tx[2] = d;
        tx[3] = crc8(tx, 3) ^ {7'h00, bad[0]};
        ssl_host_model_inst.frame(tx, (check_byte_disable_i || bad == 2'd2) ? 3 : 4, rx);
    endtask
    task automatic send_read(input logic [5:0] a, input logic [7:0] r, input int cnt);
        tx = '{default: 8'h00};
        tx[0] = {1'b0, a, 1'b0};
        tx[1] = r;
        tx[2] = 8'(cnt);
        ssl_host_model_inst.frame(tx, 3 + cnt + (check_byte_disable_i ? 0 : 1), rx);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic t_write_ok();
        popped.delete();
        cs_seen = 0;
        send_write(6'h05, 8'h12, 8'h9c, 2'd0);
        check("popped count", popped.size(), 1);
        check("written entry", popped[0], 16'h129c);
        check("check error", crc_error_o, 0);
        check("north select seen", cs_seen > 0, 1);
        check("north data", north_shift, {tx[0], tx[1], tx[2], tx[3]});
        check("north idle select", north_cs_o, 0);
        check("north idle clock", north_sclk_o, 0);
        check("output enable seen", oe_seen > 0, 1);
        check("output enable idle", host_serial_out_oe_o, 0);
        $display("write test done");
    endtask
    task automatic t_stall();
        @(posedge clock_i);
        wr_ready_i <= 1'b0;
        popped.delete();
        for (int i = 1; i <= 3; i++) send_write(6'h05, 8'(i), 8'(8'h40 + i), 2'd0);
        check("held valid", wr_valid_o, 1);
        check("nothing taken", popped.size(), 0);
        @(posedge clock_i);
        wr_ready_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("drained", popped.size(), 3);
        for (int i = 0; i < 3; i++) check("order", popped[i], {8'(i + 1), 8'(8'h41 + i)});
        $display("stall test done");
    endtask
    task automatic t_bad();
        for (int m = 1; m <= 2; m++) begin
            popped.delete();
            send_write(6'h05, 8'h07, 8'h11, 2'(m));
            check("bad discarded", popped.size(), 0);
            check("error set", crc_error_o, 1);
            check("fault out", fault_o, 1);
            check("south alert", south_alert_o, 1);
            send_read(6'h05, 8'h00, 1);
            check("flag of earlier packet", crc_error_o, 1);
            @(posedge clock_i);
            fault_clear_i <= 1'b1;
            @(posedge clock_i);
            fault_clear_i <= 1'b0;
            repeat (2) @(posedge clock_i);
            check("flag cleared", crc_error_o, 0);
            check("alert cleared", south_alert_o, 0);
        end
        $display("bad check test done");
    endtask
    task automatic t_read();
        logic [7:0] e [16];
        send_read(6'h05, 8'h20, 2);
        e = tx;
        for (int i = 0; i < 2; i++) begin
            e[3 + i] = (8'h20 + 8'(i)) ^ 8'h5a;
            check("read byte", rx[3 + i], e[3 + i]);
        end
        check("read check byte", rx[5], crc8(e, 5));
        send_read(6'h06, 8'h20, 1);
        check("foreign read silent", rx[3], 0);
        $display("read test done");
    endtask
    task automatic t_addr();
        popped.delete();
        send_write(6'h06, 8'h01, 8'h02, 2'd0);
        check("foreign ignored", popped.size(), 0);
        send_write(SSL_BCAST_ADDR, 8'h03, 8'h04, 2'd0);
        check("broadcast taken", popped.size(), 1);
        @(posedge clock_i);
        dev_addr_i <= 6'h00;
        cs_seen = 0;
        send_write(6'h00, 8'h05, 8'h06, 2'd0);
        check("select blocked", cs_seen, 0);
        check("unaddressed ignored", popped.size(), 1);
        @(posedge clock_i);
        dev_addr_i <= 6'h05;
        $display("address test done");
    endtask
    task automatic t_nocrc();
        @(posedge clock_i);
        check_byte_disable_i <= 1'b1;
        popped.delete();
        tx[0] = 8'h0b;
        ssl_host_model_inst.frame(tx, 1, rx);
        send_write(6'h05, 8'h30, 8'h31, 2'd0);
        check("after abort", popped.size(), 1);
        check("no error", crc_error_o, 0);
        send_read(6'h05, 8'h22, 1);
        check("read data", rx[3], 8'h22 ^ 8'h5a);
        // same read clocked one byte longer: no check byte may follow the data
        ssl_host_model_inst.frame(tx, 5, rx);
        check("read data again", rx[3], 8'h22 ^ 8'h5a);
        check("no check byte", rx[4], 0);
        @(posedge clock_i);
        check_byte_disable_i <= 1'b0;
        $display("no check test done");
    endtask
    task automatic t_stacked();
        @(posedge clock_i);
        base_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        popped.delete();
        oe_seen = 0;
        send_write(6'h05, 8'h44, 8'h55, 2'd0);
        check("stacked write", popped.size(), 1);
        check("stacked entry", popped[0], 16'h4455);
        send_read(6'h05, 8'h10, 1);
        check("stacked read", rx[3], 8'h10 ^ 8'h5a);
        tx[3] = 8'h10 ^ 8'h5a;
        check("stacked check byte", rx[4], crc8(tx, 4));
        check("host pins unused", oe_seen, 0);
        @(posedge clock_i);
        base_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        $display("stacked test done");
    endtask
    task automatic t_alert();
        @(posedge clock_i);
        north_alert_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        check("alert relayed", south_alert_o, 1);
        north_alert_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check("alert gone", south_alert_o, 0);
        $display("alert test done");
    endtask

    initial begin
        resetn_i = 1'b0;
        base_i = 1'b1;
        dev_addr_i = 6'h05;
        check_byte_disable_i = 1'b0;
        fault_clear_i = 1'b0;
        wr_ready_i = 1'b1;
        north_alert_i = 1'b0;
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        t_write_ok();
        t_stall();
        t_bad();
        t_read();
        t_addr();
        t_nocrc();
        t_stacked();
        t_alert();
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge clock_i);
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
